// ---- fss_top.sv ----
// output stage: write saturation, barrel shifter, core configuration
`timescale 1ns/1ps
// Operation
// - enabled: positive overflow writes 0x7FFF
// - enabled: negative overflow writes 0x8000
// - overflow sign comes from accumulator bit 39
// - disabled: rounded word passes unchanged
// - saturation never alters the source accumulator
// - shift up to sixteen bits in one cycle
// - operand from either accumulator or X bus
// - signed amount: positive right, negative left
// - 40-bit datapath, 40-bit and 16-bit results
// - X word at 16..31 right, 0..15 left
// - writing one ends loop; reads zero
// - loop depth read-only in bits 10..8
// - priority msb joins three status bits
module fss_top (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic [fss_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [15:0] O_REG_RDATA,
  input wire logic [2:0] I_LOOP_DEPTH,
  input wire logic I_PRIO_MSB_SET,
  input wire logic [15:0] I_STATUS_WORD,
  output logic O_LOOP_EXIT,
  output logic [15:0] O_CORE_CONFIG,
  output logic [3:0] O_PRIORITY_LEVEL,
  input wire logic I_WR_EN,
  input wire logic [15:0] I_ROUND_DATA,
  input wire logic [39:0] I_SRC_ACC,
  input wire logic I_ROUND_OVF,
  output logic O_DMEM_WE,
  output logic [15:0] O_DMEM_WDATA,
  input wire logic I_SHF_GO,
  input wire fss_pkg::fss_src_t I_SHF_SRC,
  input wire logic [39:0] I_ACCA,
  input wire logic [39:0] I_ACCB,
  input wire logic [15:0] I_XBUS,
  input wire logic signed [5:0] I_SHF_AMT,
  input wire logic I_SHF_ARITH,
  output logic O_SHF_VALID,
  output logic [39:0] O_SHF_RESULT,
  output logic [15:0] O_SHF_WORD
);
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic prio_msb;
  logic next_prio_msb;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic loop_exit;
  logic next_loop_exit;
  logic [3:0] prio_level;
  logic [3:0] next_prio_level;
  logic cfg_hit;
  logic [15:0] cfg_view;
  logic [15:0] core_view;
  logic [15:0] next_core_view;

  logic dmem_we;
  logic next_dmem_we;
  logic [15:0] dmem_wdata;
  logic [15:0] next_dmem_wdata;
  logic [15:0] sat_data;

  logic shf_valid;
  logic next_shf_valid;
  logic [39:0] shf_result;
  logic [39:0] next_shf_result;
  logic [15:0] shf_word;
  logic [15:0] next_shf_word;
  logic [39:0] shf_comb;
  logic [15:0] shf_comb_word;

  // saturation sees only copies of the accumulator; nothing drives it back
  fss_write_sat u_sat (
    .i_enable (cfg[fss_pkg::SAT_EN_BIT]),
    .i_round (I_ROUND_DATA),
    .i_acc (I_SRC_ACC),
    .i_rnd_ovf (I_ROUND_OVF),
    .o_data (sat_data)
  );

  fss_shifter u_shf (
    .i_src (I_SHF_SRC),
    .i_acca (I_ACCA),
    .i_accb (I_ACCB),
    .i_xbus (I_XBUS),
    .i_amt (I_SHF_AMT),
    .i_arith (I_SHF_ARITH),
    .o_result (shf_comb),
    .o_word (shf_comb_word)
  );

  // configuration register and its readback
  always_comb begin
    cfg_hit = I_REG_ADDR == fss_pkg::CORE_CFG_OFFSET;
    cfg_view = cfg;
    cfg_view[fss_pkg::EXIT_BIT] = 1'b0;
    cfg_view[fss_pkg::DEPTH_MSB:fss_pkg::DEPTH_LSB] = I_LOOP_DEPTH;
    cfg_view[fss_pkg::PRIO_MSB_BIT] = prio_msb;
    next_cfg = cfg;
    next_prio_msb = prio_msb;
    next_loop_exit = 1'b0;
    next_rdata = 16'h0000;
    if (I_REG_WR && cfg_hit) begin
      next_cfg = I_REG_WDATA & fss_pkg::CORE_CFG_WR_MASK;
      next_loop_exit = I_REG_WDATA[fss_pkg::EXIT_BIT];
      if (!I_REG_WDATA[fss_pkg::PRIO_MSB_BIT]) begin
        next_prio_msb = 1'b0;
      end
    end
    if (I_PRIO_MSB_SET) begin
      next_prio_msb = 1'b1;
    end
    if (I_REG_RD && cfg_hit) begin
      next_rdata = cfg_view;
    end
    // exported view is registered from the next state of its parts
    next_core_view = next_cfg;
    next_core_view[fss_pkg::EXIT_BIT] = 1'b0;
    next_core_view[fss_pkg::DEPTH_MSB:fss_pkg::DEPTH_LSB] = I_LOOP_DEPTH;
    next_core_view[fss_pkg::PRIO_MSB_BIT] = next_prio_msb;
    next_prio_level = {prio_msb,
      I_STATUS_WORD[fss_pkg::STATUS_PRIO_MSB:fss_pkg::STATUS_PRIO_LSB]};
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg <= fss_pkg::CORE_CFG_RESET;
      core_view <= fss_pkg::CORE_CFG_RESET;
      prio_msb <= 1'b0;
      rdata <= 16'h0000;
      loop_exit <= 1'b0;
      prio_level <= 4'h0;
    end else begin
      cfg <= next_cfg;
      core_view <= next_core_view;
      prio_msb <= next_prio_msb;
      rdata <= next_rdata;
      loop_exit <= next_loop_exit;
      prio_level <= next_prio_level;
    end
  end

  // data memory write stage
  always_comb begin
    next_dmem_we = I_WR_EN;
    next_dmem_wdata = I_WR_EN ? sat_data : dmem_wdata;
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      dmem_we <= 1'b0;
      dmem_wdata <= 16'h0000;
    end else begin
      dmem_we <= next_dmem_we;
      dmem_wdata <= next_dmem_wdata;
    end
  end

  // shifter result register
  always_comb begin
    next_shf_valid = I_SHF_GO;
    next_shf_result = I_SHF_GO ? shf_comb : shf_result;
    next_shf_word = I_SHF_GO ? shf_comb_word : shf_word;
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shf_valid <= 1'b0;
      shf_result <= 40'h0000000000;
      shf_word <= 16'h0000;
    end else begin
      shf_valid <= next_shf_valid;
      shf_result <= next_shf_result;
      shf_word <= next_shf_word;
    end
  end

  assign O_REG_RDATA = rdata;
  assign O_LOOP_EXIT = loop_exit;
  assign O_CORE_CONFIG = core_view;
  assign O_PRIORITY_LEVEL = prio_level;
  assign O_DMEM_WE = dmem_we;
  assign O_DMEM_WDATA = dmem_wdata;
  assign O_SHF_VALID = shf_valid;
  assign O_SHF_RESULT = shf_result;
  assign O_SHF_WORD = shf_word;

  // checks
  logic src_ovf;
  always_comb begin
    src_ovf = I_ROUND_OVF ||
      !((&I_SRC_ACC[39:31]) || !(|I_SRC_ACC[39:31]));
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_ARST_N);

  sat_pos_max_a: assert property (
    I_WR_EN && cfg[fss_pkg::SAT_EN_BIT] && src_ovf && !I_SRC_ACC[39]
    |=> O_DMEM_WE && O_DMEM_WDATA == 16'h7FFF)
    else $error("positive overflow not saturated");

  sat_neg_max_a: assert property (
    I_WR_EN && cfg[fss_pkg::SAT_EN_BIT] && src_ovf && I_SRC_ACC[39]
    |=> O_DMEM_WE && O_DMEM_WDATA == 16'h8000)
    else $error("negative overflow not saturated");

  sat_sign_src_a: assert property (
    I_WR_EN && cfg[fss_pkg::SAT_EN_BIT] && src_ovf
    |=> O_DMEM_WDATA[15] == $past(I_SRC_ACC[39]))
    else $error("saturation sign not from bit 39");

  sat_pass_through_a: assert property (
    I_WR_EN && !cfg[fss_pkg::SAT_EN_BIT]
    |=> O_DMEM_WDATA == $past(I_ROUND_DATA))
    else $error("disabled saturation altered data");

  sat_no_ovf_a: assert property (
    I_WR_EN && !src_ovf |=> O_DMEM_WE && O_DMEM_WDATA == $past(I_ROUND_DATA))
    else $error("in-range word altered or delayed");

  shift_one_cycle_a: assert property (
    I_SHF_GO |=> O_SHF_VALID ##1 (O_SHF_VALID == $past(I_SHF_GO)))
    else $error("shift result not ready in one cycle");

  shift_zero_amt_a: assert property (
    I_SHF_GO && I_SHF_AMT == 6'sd0 && I_SHF_SRC == fss_pkg::FSS_SRC_ACCA
    |=> O_SHF_RESULT == $past(I_ACCA))
    else $error("zero shift changed operand");

  shift_left_acc_a: assert property (
    I_SHF_GO && I_SHF_AMT == -6'sd16 && I_SHF_SRC == fss_pkg::FSS_SRC_ACCB
    |=> O_SHF_RESULT == {$past(I_ACCB[23:0]), 16'h0000})
    else $error("left shift wrong");

  shift_xbus_right_a: assert property (
    I_SHF_GO && I_SHF_AMT == 6'sd4 && I_SHF_ARITH &&
    I_SHF_SRC == fss_pkg::FSS_SRC_XBUS
    |=> O_SHF_RESULT[31:0] ==
        {{4{$past(I_XBUS[15])}}, $past(I_XBUS), 12'h000})
    else $error("X bus right placement wrong");

  loop_exit_pulse_a: assert property (
    I_REG_WR && cfg_hit && I_REG_WDATA[11]
    |=> O_LOOP_EXIT ##1 (!O_LOOP_EXIT || $past(I_REG_WR)))
    else $error("loop exit not a single pulse");

  exit_reads_zero_a: assert property (
    I_REG_RD |=> O_REG_RDATA[11] == 1'b0)
    else $error("loop exit bit read as one");

  depth_readback_a: assert property (
    I_REG_RD && cfg_hit |=> O_REG_RDATA[10:8] == $past(I_LOOP_DEPTH))
    else $error("loop depth readback wrong");

  prio_join_a: assert property (
    I_ARST_N |=> O_PRIORITY_LEVEL[2:0] == $past(I_STATUS_WORD[7:5]))
    else $error("priority low bits wrong");

  prio_set_wins_a: assert property (
    I_PRIO_MSB_SET |=> O_CORE_CONFIG[3] ##1 O_PRIORITY_LEVEL[3])
    else $error("priority msb set lost");

  shift_arith_fill_a: assert property (
    I_SHF_GO && I_SHF_AMT == 6'sd4 && I_SHF_ARITH &&
    I_SHF_SRC == fss_pkg::FSS_SRC_ACCA
    |=> O_SHF_RESULT == {{4{$past(I_ACCA[39])}}, $past(I_ACCA[39:4])})
    else $error("arithmetic shift lost the sign");

  shift_xbus_left_a: assert property (
    I_SHF_GO && I_SHF_AMT == -6'sd4 && I_SHF_SRC == fss_pkg::FSS_SRC_XBUS
    |=> O_SHF_RESULT == {20'h00000, $past(I_XBUS), 4'h0})
    else $error("X bus left placement wrong");

  shift_word_right_a: assert property (
    I_SHF_GO && I_SHF_AMT > 6'sd0
    |=> O_SHF_WORD == O_SHF_RESULT[31:16])
    else $error("integer result of right shift wrong");

  dmem_we_copy_a: assert property (
    I_ARST_N |=> O_DMEM_WE == $past(I_WR_EN))
    else $error("write enable delayed or lost");

  view_depth_a: assert property (
    I_ARST_N |=> O_CORE_CONFIG[10:8] == $past(I_LOOP_DEPTH))
    else $error("loop depth view wrong");

  view_exit_zero_a: assert property (
    O_CORE_CONFIG[11] == 1'b0)
    else $error("loop exit bit visible as one");

  prio_clear_a: assert property (
    I_REG_WR && cfg_hit && !I_REG_WDATA[3] && !I_PRIO_MSB_SET
    |=> !O_CORE_CONFIG[3])
    else $error("priority msb not cleared");
endmodule : fss_top

// ---- fss_pkg.sv ----
// constants and types shared by the fractional saturation and shift logic
package fss_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CORE_CFG_OFFSET = 4'h0;
  localparam logic [15:0] CORE_CFG_RESET = 16'h0020;
  localparam logic [15:0] CORE_CFG_WR_MASK = 16'h10F7;
  localparam int EXIT_BIT = 11;
  localparam int DEPTH_LSB = 8;
  localparam int DEPTH_MSB = 10;
  localparam int SAT_EN_BIT = 5;
  localparam int PRIO_MSB_BIT = 3;
  localparam int STATUS_PRIO_LSB = 5;
  localparam int STATUS_PRIO_MSB = 7;
  localparam int ACC_SIGN_BIT = 39;
  localparam int FRAC_SIGN_BIT = 31;
  localparam logic [15:0] SAT_POS_WORD = 16'h7FFF;
  localparam logic [15:0] SAT_NEG_WORD = 16'h8000;
  localparam logic [4:0] SHIFT_MAX = 5'h10;
  localparam int XBUS_RIGHT_LSB = 16;
  typedef enum logic [1:0] {
    FSS_SRC_ACCA,
    FSS_SRC_ACCB,
    FSS_SRC_XBUS
  } fss_src_t;
endpackage : fss_pkg

// ---- fss_write_sat.sv ----
// data write saturation of a rounded 1.15 word
`timescale 1ns/1ps
module fss_write_sat (
  input wire logic i_enable,
  input wire logic [15:0] i_round,
  input wire logic [39:0] i_acc,
  input wire logic i_rnd_ovf,
  output logic [15:0] o_data
);
  logic acc_ovf;
  logic sign;

  always_comb begin
    // source bits above the 1.15 range must all match the sign
    acc_ovf = !((&i_acc[fss_pkg::ACC_SIGN_BIT:fss_pkg::FRAC_SIGN_BIT]) ||
                !(|i_acc[fss_pkg::ACC_SIGN_BIT:fss_pkg::FRAC_SIGN_BIT]));
    sign = i_acc[fss_pkg::ACC_SIGN_BIT];
    o_data = i_round;
    if (i_enable && (acc_ovf || i_rnd_ovf)) begin
      if (sign) begin
        o_data = fss_pkg::SAT_NEG_WORD;
      end else begin
        o_data = fss_pkg::SAT_POS_WORD;
      end
    end
  end
endmodule : fss_write_sat

// ---- fss_shifter.sv ----
// single-cycle 40-bit barrel shifter
`timescale 1ns/1ps
module fss_shifter (
  input wire fss_pkg::fss_src_t i_src,
  input wire logic [39:0] i_acca,
  input wire logic [39:0] i_accb,
  input wire logic [15:0] i_xbus,
  input wire logic signed [5:0] i_amt,
  input wire logic i_arith,
  output logic [39:0] o_result,
  output logic [15:0] o_word
);
  logic left;
  logic [5:0] abs_amt;
  logic [4:0] mag;
  logic [39:0] op;

  always_comb begin
    left = i_amt < 0;
    abs_amt = left ? 6'(-i_amt) : 6'(i_amt);
    mag = (abs_amt > 6'(fss_pkg::SHIFT_MAX)) ? fss_pkg::SHIFT_MAX
                                             : abs_amt[4:0];
    case (i_src)
      fss_pkg::FSS_SRC_ACCA: op = i_acca;
      fss_pkg::FSS_SRC_ACCB: op = i_accb;
      fss_pkg::FSS_SRC_XBUS: begin
        if (left) begin
          op = {24'h000000, i_xbus};
        end else begin
          op = {{8{i_xbus[15] & i_arith}}, i_xbus, 16'h0000};
        end
      end
      default: op = 40'h0000000000;
    endcase
    if (mag == 5'h00) begin
      o_result = op;
    end else if (left) begin
      o_result = op << mag;
    end else if (i_arith) begin
      o_result = 40'($signed(op) >>> mag);
    end else begin
      o_result = op >> mag;
    end
    // integer result: upper half word for right, low word for left
    o_word = left ? o_result[15:0]
                  : o_result[fss_pkg::XBUS_RIGHT_LSB +: 16];
  end
endmodule : fss_shifter

// ---- fss_mem_model.sv ----
// data memory write port model counting writes and keeping the last written word
`timescale 1ns/1ps
module fss_mem_model (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_we,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_last,
  output logic [7:0] o_writes
);
  logic [15:0] next_last;
  logic [7:0] next_writes;
  always_comb begin
    next_last = o_last;
    next_writes = o_writes;
    if (i_we) begin
      next_last = i_wdata;
      next_writes = o_writes + 8'h01;
    end
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_last <= 16'h0000;
      o_writes <= 8'h00;
    end else begin
      o_last <= next_last;
      o_writes <= next_writes;
    end
  end
endmodule : fss_mem_model

// ---- fractional_sat_shifter_tb.sv ----
// self-checking bench for the saturation and shift output stage
`timescale 1ns/1ps
module fractional_sat_shifter_tb;
  typedef struct {
    logic en; logic [15:0] rnd; logic [39:0] acc; logic ovf;
    logic [15:0] exp;
  } fss_sat_row_t;
  typedef struct {
    fss_pkg::fss_src_t src; logic signed [5:0] amt; logic ar;
    logic [39:0] exp;
  } fss_shf_row_t;
  fss_sat_row_t sat_rows [5] = '{
    '{1'b1, 16'h1234, 40'h0012340000, 1'b0, 16'h1234},
    '{1'b1, 16'h8000, 40'h0080000000, 1'b0, 16'h7FFF},
    '{1'b1, 16'h7FFF, 40'hFF7FFF0000, 1'b0, 16'h8000},
    '{1'b1, 16'h9000, 40'h0010000000, 1'b1, 16'h7FFF},
    '{1'b0, 16'h8000, 40'h0080000000, 1'b1, 16'h8000}};
  fss_shf_row_t shf_rows [8] = '{
    '{fss_pkg::FSS_SRC_ACCA, 6'sd4, 1'b1, 40'hFF01234567},
    '{fss_pkg::FSS_SRC_ACCA, 6'sd4, 1'b0, 40'h0F01234567},
    '{fss_pkg::FSS_SRC_ACCA, 6'sd0, 1'b1, 40'hF012345678},
    '{fss_pkg::FSS_SRC_ACCB, -6'sd16, 1'b0, 40'h0000010000},
    '{fss_pkg::FSS_SRC_ACCB, 6'sd16, 1'b0, 40'h0000008000},
    '{fss_pkg::FSS_SRC_XBUS, 6'sd4, 1'b1, 40'hFFF8421000},
    '{fss_pkg::FSS_SRC_XBUS, -6'sd4, 1'b0, 40'h0000084210},
    '{fss_pkg::FSS_SRC_XBUS, 6'sd20, 1'b0, 40'h0000008421}};
  logic clk, rst_n, wr, rd, pset, wen, ovf, go, ar, we, exit_p, valid;
  logic [3:0] addr, plev;
  logic [15:0] wdata, rdata, status, rnd, xbus, dwdata, cfg, word, v, mlast;
  logic [39:0] acc, acca, accb, res;
  logic [2:0] depth;
  logic [5:0] amt;
  logic [7:0] mwrites;
  fss_pkg::fss_src_t src;
  int fail_count, cmp_count;
  fss_top u_fss_top (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_LOOP_DEPTH(depth), .I_PRIO_MSB_SET(pset), .I_STATUS_WORD(status),
    .O_LOOP_EXIT(exit_p), .O_CORE_CONFIG(cfg), .O_PRIORITY_LEVEL(plev),
    .I_WR_EN(wen), .I_ROUND_DATA(rnd), .I_SRC_ACC(acc), .I_ROUND_OVF(ovf),
    .O_DMEM_WE(we), .O_DMEM_WDATA(dwdata), .I_SHF_GO(go), .I_SHF_SRC(src),
    .I_ACCA(acca), .I_ACCB(accb), .I_XBUS(xbus), .I_SHF_AMT(amt),
    .I_SHF_ARITH(ar), .O_SHF_VALID(valid), .O_SHF_RESULT(res),
    .O_SHF_WORD(word));
  fss_mem_model u_fss_mem_model (.i_clock(clk), .i_arst_n(rst_n), .i_we(we),
    .i_wdata(dwdata), .o_last(mlast), .o_writes(mwrites));
  task automatic check(input string name, input logic [39:0] seen,
                       input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
    #1 check("rdata_idle", rdata, 16'h0000);
  endtask : reg_rd
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    {rst_n, wr, rd, pset, wen, ovf, go, ar, addr, wdata, rnd, acc} = '0;
    amt = '0;
    src = fss_pkg::FSS_SRC_ACCA;
    depth = 3'h7;
    status = 16'h00A0;
    acca = 40'hF012345678;
    accb = 40'h0080000001;
    xbus = 16'h8421;
    repeat (16) @(posedge clk);
    check("cfg_reset", cfg, 16'h0020);
    rst_n <= 1'b1;
    reg_rd(4'h0, v);
    check("cfg_read", v, 16'h0720);
    reg_wr(4'h0, 16'hFFFF);
    #1 check("exit_pulse", exit_p, 1'b1);
    reg_rd(4'h0, v);
    check("cfg_all_ones", v, 16'h17F7);
    reg_rd(4'h3, v);
    check("unmapped", v, 16'h0000);
    @(posedge clk);
    pset <= 1'b1;
    @(posedge clk);
    pset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("prio_set", plev, 4'hD);
    check("prio_view", cfg, 16'h17FF);
    reg_wr(4'h0, 16'h0020);
    repeat (2) @(posedge clk);
    #1 check("prio_clear", plev, 4'h5);
    $display("test registers done");
    foreach (sat_rows[i]) begin
      reg_wr(4'h0, sat_rows[i].en ? 16'h0020 : 16'h0000);
      @(posedge clk);
      wen <= 1'b1;
      rnd <= sat_rows[i].rnd;
      acc <= sat_rows[i].acc;
      ovf <= sat_rows[i].ovf;
      @(posedge clk);
      wen <= 1'b0;
      #1 check("dmem_we", we, 1'b1);
      check("dmem", dwdata, sat_rows[i].exp);
    end
    @(posedge clk);
    #1 check("mem_writes", mwrites, 8'h05);
    check("mem_last", mlast, 16'h8000);
    $display("test saturation done");
    foreach (shf_rows[i]) begin
      @(posedge clk);
      go <= 1'b1;
      src <= shf_rows[i].src;
      amt <= shf_rows[i].amt;
      ar <= shf_rows[i].ar;
      @(posedge clk);
      go <= 1'b0;
      #1 check("shf_valid", valid, 1'b1);
      check("shf_result", res, shf_rows[i].exp);
      if (shf_rows[i].amt != 0)
        check("shf_word", word, shf_rows[i].amt < 0 ? shf_rows[i].exp[15:0]
              : shf_rows[i].exp[31:16]);
    end
    $display("test shifter done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("rst_cfg", cfg, 16'h0020);
    check("rst_res", res, 40'h0000000000);
    check("rst_dmem", dwdata, 16'h0000);
    check("rst_plev", plev, 4'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(4'h0, v);
    check("cfg_after_reset", v, 16'h0720);
    $display("test reset done");
    test_done();
  end
endmodule : fractional_sat_shifter_tb
